// File: dv/alarm_ctl_monitor.sv
`timescale 1ns/100ps
module alarm_ctl_monitor (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// register writes
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	// line status
	input wire logic i_loss_of_frame_alignment,
	input wire logic i_frame_alignment_word_ok,
	input wire logic i_mf_alignment_ok,
	// transmit and alarms
	input wire logic i_tx_bit,
	input wire logic i_tx_valid,
	input wire logic [4:0] i_tx_slot,
	input wire logic o_tx_bit,
	input wire logic o_red_alarm,
	input wire logic o_yellow_tx,
	input wire logic o_mf_yellow_tx
);
	logic [7:0] c_r;
	logic p, q;
	logic [1:0] y, g;
	assign p = i_tx_valid && !c_r[7];
	assign q = i_tx_valid && c_r[7];
	assign y = c_r[5:4];
	assign g = c_r[3:2];
	// shadow of the control register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			c_r <= 8'h00;
		end else if (i_wr && i_addr == 8'h08) begin
			c_r <= i_wdata;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	a_red_gated: assert property (
		o_red_alarm == $past(c_r[6] && i_loss_of_frame_alignment)) else $error("red alarm");
	a_yellow_fixed: assert property (
		$past(y) != 2'h1 |-> {o_yellow_tx, o_mf_yellow_tx} == {2{$past(y) == 2'h3}}) else $error("yellow");
	a_yellow_echo: assert property (
		$past(y) == 2'h1 |-> o_yellow_tx == $past(!i_frame_alignment_word_ok || i_loss_of_frame_alignment))
		else $error("yellow echo");
	a_mf_yellow_echo: assert property (
		$past(y) == 2'h1 |-> o_mf_yellow_tx != $past(i_mf_alignment_ok)) else $error("mf yellow");
	a_aux_toggle: assert property (
		$past(q, 2) && $past(q) |-> o_tx_bit != $past(o_tx_bit)) else $error("aux pattern");
	a_ais_unframed: assert property (
		$past(p && g == 2'h1) |-> o_tx_bit) else $error("unframed ones");
	a_ais_framed: assert property (
		$past(p && g == 2'h3 && i_tx_slot != 5'h00) |-> o_tx_bit) else $error("framed ones");
	a_ais_slot16: assert property (
		$past(p && g == 2'h2 && i_tx_slot == 5'h10) |-> o_tx_bit) else $error("slot 16 ones");
	a_data_kept: assert property (
		$past(p && y == 2'h0 && (g == 2'h0 || (g == 2'h2 && i_tx_slot != 5'h10)
		|| (g == 2'h3 && i_tx_slot == 5'h00))) |-> o_tx_bit == $past(i_tx_bit)) else $error("data");
endmodule : alarm_ctl_monitor
bind e1_alarm_generation_control alarm_ctl_monitor alarm_ctl_monitor_inst (.*);

// File: dv/line_partner.sv
`timescale 1ns/100ps
module line_partner (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// 0 data, 1 all ones, 2 slot 16 ones, 3 framed ones
	input wire logic [1:0] i_kind,
	// receive stream
	output logic o_bit,
	output logic [7:0] o_pos
);
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pos <= 8'h00;
		end else begin
			o_pos <= o_pos + 8'h01;
		end
	end
	assign o_bit = o_pos[0] || i_kind == 2'h1 || (i_kind == 2'h2 && o_pos[7:3] == 5'h10)
		|| (i_kind == 2'h3 && o_pos[7:3] != 5'h00);
endmodule : line_partner

// File: dv/tb_e1_alarm_generation_control.sv
`timescale 1ns/100ps
module tb_e1_alarm_generation_control;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic loss_of_frame_alignment = 1'b0;
	logic frame_alignment_word = 1'b1;
	logic mfa = 1'b1;
	logic yb = 1'b0;
	logic myb = 1'b0;
	logic txv;
	logic [1:0] kind = 2'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] tcnt = 8'h00;
	logic [7:0] rdata, rpos;
	logic irq, rxb, otx, red, aisd, yel, mfy;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		tcnt <= tcnt + 8'h01;
		cycles++;
		if (cycles == 10000) begin
			fails++;
			conclude();
		end
	end
	e1_alarm_generation_control e1_alarm_generation_control_inst (
		.i_clock(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_loss_of_frame_alignment(loss_of_frame_alignment),
		.i_frame_alignment_word_ok(frame_alignment_word), .i_mf_alignment_ok(mfa), .i_rx_bit(rxb),
		.i_rx_valid(rstn), .i_rx_slot(rpos[7:3]), .i_rx_frame_end(rpos == 8'hff),
		.i_tx_bit(tcnt[1]), .i_tx_valid(rstn), .i_tx_slot(tcnt[7:3]), .i_tx_is_yellow(yb),
		.i_tx_is_mf_yellow(myb), .o_tx_bit(otx), .o_tx_valid(txv), .o_red_alarm(red),
		.o_ais_detected(aisd), .o_yellow_tx(yel), .o_mf_yellow_tx(mfy));
	line_partner line_partner_inst (.i_clock(clk), .i_resetn(rstn), .i_kind(kind),
		.o_bit(rxb), .o_pos(rpos));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp(rdata, exp);
	endtask : rchk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic t_reset;
		rchk(8'h08, 8'h00);
		rchk(8'h0b, 8'h00);
		wreg(8'h3f, 8'hff);
		wreg(8'h08, 8'ha5);
		rchk(8'h08, 8'ha5);
		rchk(8'h3f, 8'h00);
	endtask : t_reset
	task automatic t_aux;
		logic [3:0] b;
		wreg(8'h08, 8'h80);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#1 b[i] = otx;
		end
		cmp({5'h00, b[3] ^ b[2], b[2] ^ b[1], b[1] ^ b[0]}, 8'h07);
		cmp({7'h00, txv}, 8'h01);
	endtask : t_aux
	task automatic t_lof;
		wreg(8'h08, 8'h50);
		@(posedge clk) frame_alignment_word <= 1'b0;
		loss_of_frame_alignment <= 1'b1;
		wt(3);
		cmp({5'h00, red, yel, irq}, 8'h06);
		rchk(8'h0a, 8'h01);
		wreg(8'h0b, 8'h01);
		wt(2);
		cmp({7'h00, irq}, 8'h01);
		wreg(8'h0a, 8'h01);
		wt(2);
		cmp({7'h00, irq}, 8'h00);
		wreg(8'h08, 8'h10);
		wt(2);
		cmp({6'h00, red, yel}, 8'h01);
		@(posedge clk) loss_of_frame_alignment <= 1'b0;
		frame_alignment_word <= 1'b1;
	endtask : t_lof
	task automatic t_yellow;
		logic [1:0] m, e;
		logic f;
		logic pb, pb2, ob;
		for (int i = 0; i < 8; i++) begin
			m = i[2:1];
			f = i[0];
			wreg(8'h08, {2'h0, m, 4'h0});
			@(posedge clk) frame_alignment_word <= f;
			mfa <= !f;
			wt(3);
			e = {m == 2'h3 || (m == 2'h1 && !f), m == 2'h3 || (m == 2'h1 && f)};
			cmp({6'h00, yel, mfy}, {6'h00, e});
			// yellow then multiframe yellow position on the line
			@(posedge clk) yb <= 1'b1;
			#1 pb = tcnt[1];
			@(posedge clk) yb <= 1'b0;
			myb <= 1'b1;
			#1 ob = otx;
			pb2 = tcnt[1];
			@(posedge clk) myb <= 1'b0;
			#1 cmp({6'h00, ob, otx}, {6'h00, (m == 2'h0) ? {pb, pb2} : e});
		end
	endtask : t_yellow
	task automatic t_aisgen;
		logic [4:0] ps;
		logic pb, e;
		int bad;
		for (int g = 0; g < 4; g++) begin
			wreg(8'h08, {4'h0, g[1:0], 2'h0});
			bad = 0;
			#1;
			for (int j = 0; j < 256; j++) begin
				ps = tcnt[7:3];
				pb = tcnt[1];
				wt(1);
				e = (g == 1 || (g == 3 && ps != 5'h00) || (g == 2 && ps == 5'h10)) ? 1'b1 : pb;
				bad += (otx !== e);
			end
			cmp({7'h00, bad != 0}, 8'h00);
		end
	endtask : t_aisgen
	task automatic t_aisdet;
		logic [4:0] tab [6];
		tab = '{5'h0b, 5'h08, 5'h15, 5'h16, 5'h1f, 5'h1a};
		foreach (tab[i]) begin
			@(posedge clk) kind <= tab[i][4:3];
			wreg(8'h08, {6'h00, tab[i][2:1]});
			wt(800);
			cmp({7'h00, aisd}, {7'h00, tab[i][0]});
		end
	endtask : t_aisdet
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_aux();
		t_lof();
		t_yellow();
		t_aisgen();
		t_aisdet();
		conclude();
	end
endmodule : tb_e1_alarm_generation_control

// File: rtl/ais_detector.sv
`timescale 1ns/100ps
module ais_detector (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// line receive
	input wire logic i_rx_bit,
	input wire logic i_rx_valid,
	input wire logic [4:0] i_rx_slot,
	input wire logic i_rx_frame_end,
	// control
	alarm_ctl_if.user ctl
);
	logic ok_r;
	logic [1:0] frames_r;
	logic seen_r;
	logic [1:0] mode;
	logic care;

	assign mode = ctl.ctrl[alarm_pkg::AISD_LSB +: 2];
	assign ctl.ais_seen = seen_r;
	assign ctl.lof_red = 1'b0;

	always_comb begin
		case (mode)
			alarm_pkg::AIS_UNFRAMED: care = 1'b1;
			alarm_pkg::AIS_TS16: care = (i_rx_slot == 5'(alarm_pkg::SIG_SLOT));
			alarm_pkg::AIS_FRAMED: care = (i_rx_slot != 5'(alarm_pkg::FRAMING_SLOT));
			default: care = 1'b0;
		endcase
	end

	// frame-wise all-ones check on the selected bits
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ok_r <= 1'b1;
			frames_r <= 2'b00;
			seen_r <= 1'b0;
		end else if (mode == alarm_pkg::AIS_OFF) begin
			ok_r <= 1'b1;
			frames_r <= 2'b00;
			seen_r <= 1'b0;
		end else if (i_rx_valid) begin
			if (i_rx_frame_end) begin
				ok_r <= 1'b1;
				if (ok_r && !(care && !i_rx_bit)) begin
					if (frames_r == 2'(alarm_pkg::AIS_ONES_FRAMES - 1))
						seen_r <= 1'b1;
					else
						frames_r <= frames_r + 2'd1;
				end else begin
					frames_r <= 2'b00;
					seen_r <= 1'b0;
				end
			end else if (care && !i_rx_bit) begin
				ok_r <= 1'b0;
			end
		end
	end
endmodule : ais_detector

// File: rtl/alarm_ctl_if.sv
`timescale 1ns/100ps
interface alarm_ctl_if;
	logic [7:0] ctrl;
	logic lof_red;
	logic ais_seen;
	modport owner (output ctrl, input lof_red, input ais_seen);
	modport user (input ctrl, output lof_red, output ais_seen);
endinterface : alarm_ctl_if

// File: rtl/alarm_pkg.sv
package alarm_pkg;
	// register map
	localparam logic [7:0] ALARM_GENERATION_CONTROL_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0a;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0b;
	localparam logic [7:0] ALARM_STATE_OFFSET = 8'h0c;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	// control field positions
	localparam int AUX_BIT = 7;
	localparam int LOF_EN_BIT = 6;
	localparam int YEL_LSB = 4;
	localparam int AISG_LSB = 2;
	localparam int AISD_LSB = 0;
	// status bit positions
	localparam int IRQ_LOF_BIT = 0;
	localparam int IRQ_AIS_BIT = 1;
	localparam int IRQ_WIDTH = 2;
	// frame geometry
	localparam int BITS_PER_SLOT = 8;
	localparam int SLOTS_PER_FRAME = 32;
	localparam int SIG_SLOT = 16;
	localparam int FRAMING_SLOT = 0;
	// alarm indication detect: two full frames of ones in a row
	localparam int AIS_ONES_FRAMES = 2;

	typedef enum logic [1:0] {
		YEL_OFF = 2'b00,
		YEL_ECHO = 2'b01,
		YEL_ZERO = 2'b10,
		YEL_ONE = 2'b11
	} yellow_mode_t;

	typedef enum logic [1:0] {
		AIS_OFF = 2'b00,
		AIS_UNFRAMED = 2'b01,
		AIS_TS16 = 2'b10,
		AIS_FRAMED = 2'b11
	} ais_mode_t;
endpackage : alarm_pkg

// File: rtl/e1_alarm_generation_control.sv
`timescale 1ns/100ps
// Operation
// - control bit 7 sends unframed 1010 pattern on the line
// - bit 6 lets frame loss declare red alarm
// - frame loss sets the frame loss interrupt status bit, and raises the interrupt only when mask bit 0 is set
// - field 01: frame loss returns yellow alarm to far end
// - yellow field 00 sends neither yellow nor multiframe yellow
// - field 01: yellow bit echoes frame alignment word state
// - field 01: multiframe yellow echoes multiframe alignment state
// - field 10 sends both zero, 11 sends both one
// - alarm generate 00 off, 01 all ones including framing
// - alarm generate 10 fills timeslot 16 with ones only
// - alarm generate 11 all ones except framing bits
// - detect 00 off, 01 detects unframed all ones
// - detect 10 finds timeslot 16 all ones
// - detect 11 finds framed all ones
module e1_alarm_generation_control (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// interrupt
	output logic o_irq,
	// receive side status
	input wire logic i_loss_of_frame_alignment,
	input wire logic i_frame_alignment_word_ok,
	input wire logic i_mf_alignment_ok,
	// receive bits for alarm indication detect
	input wire logic i_rx_bit,
	input wire logic i_rx_valid,
	input wire logic [4:0] i_rx_slot,
	input wire logic i_rx_frame_end,
	// transmit bit stream
	input wire logic i_tx_bit,
	input wire logic i_tx_valid,
	input wire logic [4:0] i_tx_slot,
	input wire logic i_tx_is_yellow,
	input wire logic i_tx_is_mf_yellow,
	output logic o_tx_bit,
	output logic o_tx_valid,
	// alarm states
	output logic o_red_alarm,
	output logic o_ais_detected,
	output logic o_yellow_tx,
	output logic o_mf_yellow_tx
);
	logic [7:0] ctrl_r;
	logic [alarm_pkg::IRQ_WIDTH-1:0] status_r;
	logic [alarm_pkg::IRQ_WIDTH-1:0] mask_r;
	logic [alarm_pkg::IRQ_WIDTH-1:0] evt;
	logic lof_d_r;
	logic ais_d_r;
	logic aux_phase_r;
	logic red_r;
	logic ais_det_r;
	logic yel_r;
	logic mfy_r;
	logic tx_bit_r;
	logic tx_valid_r;
	logic irq_r;
	logic [7:0] rdata_r;
	logic yel_nxt;
	logic mfy_nxt;
	logic tx_nxt;
	logic [1:0] yel_mode;
	logic [1:0] aisg_mode;

	alarm_ctl_if ctl ();

	assign ctl.ctrl = ctrl_r;
	assign yel_mode = ctrl_r[alarm_pkg::YEL_LSB +: 2];
	assign aisg_mode = ctrl_r[alarm_pkg::AISG_LSB +: 2];

	ais_detector ais_detector_inst (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_rx_bit(i_rx_bit),
		.i_rx_valid(i_rx_valid),
		.i_rx_slot(i_rx_slot),
		.i_rx_frame_end(i_rx_frame_end),
		.ctl(ctl)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// control register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			ctrl_r <= alarm_pkg::CONTROL_RESET;
		else if (i_wr && hit(i_addr, alarm_pkg::ALARM_GENERATION_CONTROL_OFFSET))
			ctrl_r <= i_wdata;
	end

	// interrupt mask
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			mask_r <= alarm_pkg::IRQ_MASK_RESET[alarm_pkg::IRQ_WIDTH-1:0];
		else if (i_wr && hit(i_addr, alarm_pkg::IRQ_MASK_OFFSET))
			mask_r <= i_wdata[alarm_pkg::IRQ_WIDTH-1:0];
	end

	// rising-edge events
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			lof_d_r <= 1'b0;
			ais_d_r <= 1'b0;
		end else begin
			lof_d_r <= i_loss_of_frame_alignment;
			ais_d_r <= ctl.ais_seen;
		end
	end

	assign evt[alarm_pkg::IRQ_LOF_BIT] = i_loss_of_frame_alignment && !lof_d_r;
	assign evt[alarm_pkg::IRQ_AIS_BIT] = ctl.ais_seen && !ais_d_r;

	// sticky status, write one to clear, set wins
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			status_r <= '0;
		else if (i_wr && hit(i_addr, alarm_pkg::IRQ_STATUS_OFFSET))
			status_r <= (status_r & ~i_wdata[alarm_pkg::IRQ_WIDTH-1:0]) | evt;
		else
			status_r <= status_r | evt;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_r & mask_r);
	end

	// red alarm and detected alarm indication
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			red_r <= 1'b0;
			ais_det_r <= 1'b0;
		end else begin
			red_r <= ctrl_r[alarm_pkg::LOF_EN_BIT] && i_loss_of_frame_alignment;
			ais_det_r <= ctl.ais_seen;
		end
	end

	// yellow bit values
	always_comb begin
		case (yel_mode)
			alarm_pkg::YEL_ECHO: begin
				yel_nxt = !i_frame_alignment_word_ok || i_loss_of_frame_alignment;
				mfy_nxt = !i_mf_alignment_ok;
			end
			alarm_pkg::YEL_ZERO: begin
				yel_nxt = 1'b0;
				mfy_nxt = 1'b0;
			end
			alarm_pkg::YEL_ONE: begin
				yel_nxt = 1'b1;
				mfy_nxt = 1'b1;
			end
			default: begin
				yel_nxt = 1'b0;
				mfy_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			yel_r <= 1'b0;
			mfy_r <= 1'b0;
		end else begin
			yel_r <= yel_nxt;
			mfy_r <= mfy_nxt;
		end
	end

	// transmit bit selection
	always_comb begin
		tx_nxt = i_tx_bit;
		if (i_tx_is_yellow && yel_mode != alarm_pkg::YEL_OFF)
			tx_nxt = yel_nxt;
		if (i_tx_is_mf_yellow && yel_mode != alarm_pkg::YEL_OFF)
			tx_nxt = mfy_nxt;
		case (aisg_mode)
			alarm_pkg::AIS_UNFRAMED: tx_nxt = 1'b1;
			alarm_pkg::AIS_TS16: begin
				if (i_tx_slot == 5'(alarm_pkg::SIG_SLOT))
					tx_nxt = 1'b1;
			end
			alarm_pkg::AIS_FRAMED: begin
				if (i_tx_slot != 5'(alarm_pkg::FRAMING_SLOT))
					tx_nxt = 1'b1;
			end
			default: ;
		endcase
		if (ctrl_r[alarm_pkg::AUX_BIT])
			tx_nxt = aux_phase_r;
	end

	// 1010 phase, advances each line bit
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			aux_phase_r <= 1'b1;
		else if (!ctrl_r[alarm_pkg::AUX_BIT])
			aux_phase_r <= 1'b1;
		else if (i_tx_valid)
			aux_phase_r <= !aux_phase_r;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_bit_r <= 1'b0;
			tx_valid_r <= 1'b0;
		end else begin
			tx_bit_r <= tx_nxt;
			tx_valid_r <= i_tx_valid;
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			rdata_r <= 8'h00;
		else if (i_rd) begin
			case (i_addr)
				alarm_pkg::ALARM_GENERATION_CONTROL_OFFSET: rdata_r <= ctrl_r;
				alarm_pkg::IRQ_STATUS_OFFSET: rdata_r <= 8'(status_r);
				alarm_pkg::IRQ_MASK_OFFSET: rdata_r <= 8'(mask_r);
				alarm_pkg::ALARM_STATE_OFFSET: rdata_r <= {4'h0, mfy_r, yel_r, ais_det_r, red_r};
				default: rdata_r <= 8'h00;
			endcase
		end else
			rdata_r <= 8'h00;
	end

	assign o_rdata = rdata_r;
	assign o_irq = irq_r;
	assign o_tx_bit = tx_bit_r;
	assign o_tx_valid = tx_valid_r;
	assign o_red_alarm = red_r;
	assign o_ais_detected = ais_det_r;
	assign o_yellow_tx = yel_r;
	assign o_mf_yellow_tx = mfy_r;
endmodule : e1_alarm_generation_control
